// file: self_test_pkg.sv
// Constants and types shared by the processor self-test supervisor.
// Assumes a single 100 MHz system clock with synchronous active-high reset.
package self_test_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SIG_WIDTH = 512;
  localparam int unsigned SLICE_WIDTH = 8;
  localparam int unsigned CHAIN_COUNT = 16;
  // Completion window for one run, in microseconds.
  localparam int unsigned RUN_TIMEOUT_US = 200;
  localparam int unsigned RUN_TIMEOUT_CYC = (RUN_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  // Core reset pulse length in nanoseconds.
  localparam int unsigned CORE_RESET_NS = 80;
  localparam int unsigned CORE_RESET_CYC =
    (CORE_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PATTERNS_PER_SLICE = 64;
  localparam logic [31:0] LFSR_SEED = 32'hACE1_0001;
  localparam logic [31:0] LFSR_TAPS = 32'h8020_0003;

  // Fault-injection selections.
  typedef enum logic [1:0] {
    INJ_NONE,
    INJ_SIGNATURE,
    INJ_HANG
  } inject_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SAVE,
    ST_SCAN,
    ST_CHECK,
    ST_RESET,
    ST_RESTORE
  } state_t;
endpackage

// file: signature_compactor.sv
`timescale 1ns/1ps
// Multiple-input signature register that compacts scan responses.
// Assumes the caller clears it before each run and steps it once per shift.
module signature_compactor
  import self_test_pkg::*;
#(
  parameter int unsigned WIDTH = SIG_WIDTH,
  parameter int unsigned IN_WIDTH = CHAIN_COUNT
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Control.
  input wire logic clear,
  input wire logic step,
  input wire logic [IN_WIDTH-1:0] response,
  // Result.
  output logic [WIDTH-1:0] signature
);
  logic [WIDTH-1:0] sig_r;

  always_ff @(posedge clk) begin
    if (rst || clear) begin
      sig_r <= '0;
    end else if (step) begin
      // Shift with feedback, folding the responses into the low bits.
      sig_r <= {sig_r[WIDTH-2:0], sig_r[WIDTH-1] ^ sig_r[WIDTH/2] ^ sig_r[1]}
               ^ {{(WIDTH-IN_WIDTH){1'b0}}, response};
    end
  end

  assign signature = sig_r;
endmodule

// file: cpu_self_test_supervisor.sv
`timescale 1ns/1ps
// Supervisor for the processor built-in self-test engine.
// Assumes the core drives start and slice selection and honours the scan and reset outputs.
module cpu_self_test_supervisor
  import self_test_pkg::*;
#(
  parameter int unsigned NUM_CORES = 2,
  parameter int unsigned NUM_SLICES = 16,
  parameter int unsigned TIMEOUT_CYCLES = RUN_TIMEOUT_CYC,
  parameter int unsigned SLICE_PATTERNS = PATTERNS_PER_SLICE,
  parameter logic [SIG_WIDTH-1:0] EXPECTED_SIG = '0
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Software request from the core.
  input wire logic start,
  input wire logic run_all,
  input wire logic [SLICE_WIDTH-1:0] slice_first,
  input wire logic [SLICE_WIDTH-1:0] slice_count,
  input wire logic [1:0] inject_sel,
  input wire logic status_clear,
  // Scan chain access.
  output logic scan_enable,
  output logic [CHAIN_COUNT-1:0] scan_in,
  input wire logic [CHAIN_COUNT-1:0] scan_out,
  // Core context and reset.
  output logic context_save,
  output logic context_restore,
  output logic core_reset,
  // Error signalling.
  output logic [NUM_CORES-1:0] nmi,
  output logic error_status_pin,
  // Status held across the core reset.
  output logic busy,
  output logic stat_done,
  output logic stat_pass,
  output logic stat_mismatch,
  output logic stat_timeout,
  output logic [SIG_WIDTH-1:0] stat_signature
);
  state_t state_r;
  logic [31:0] timer_r;
  logic [31:0] lfsr_r;
  logic [15:0] pat_r;
  logic [SLICE_WIDTH-1:0] slice_r;
  logic [SLICE_WIDTH-1:0] last_slice_r;
  logic [7:0] rst_cnt_r;
  inject_t inject_r;
  logic fail_r;
  logic sig_clear;
  logic sig_step;
  logic [SIG_WIDTH-1:0] signature;
  logic timeout_hit;
  logic slice_end;

  assign timeout_hit = (state_r == ST_SCAN) && (timer_r >= TIMEOUT_CYCLES - 1);
  assign slice_end = (pat_r == 16'(SLICE_PATTERNS - 1));
  // A hang injection freezes pattern stepping so the run can only end by timeout.
  assign sig_step = (state_r == ST_SCAN) && (inject_r != INJ_HANG);
  assign sig_clear = (state_r == ST_SAVE);

  signature_compactor #(
    .WIDTH(SIG_WIDTH),
    .IN_WIDTH(CHAIN_COUNT)
  ) u_compactor (
    .clk(clk),
    .rst(rst),
    .clear(sig_clear),
    .step(sig_step),
    .response(scan_out),
    .signature(signature)
  );

  // Main sequence.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: if (start) state_r <= ST_SAVE;
        ST_SAVE: state_r <= ST_SCAN;
        ST_SCAN: begin
          if (timeout_hit) begin
            state_r <= ST_RESET;
          end else if (sig_step && slice_end && slice_r == last_slice_r) begin
            state_r <= ST_CHECK;
          end
        end
        ST_CHECK: state_r <= ST_RESET;
        ST_RESET: if (rst_cnt_r == 8'(CORE_RESET_CYC - 1)) state_r <= ST_RESTORE;
        ST_RESTORE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Slice range and fault selection captured at start.
  always_ff @(posedge clk) begin
    if (rst) begin
      slice_r <= '0;
      last_slice_r <= '0;
      inject_r <= INJ_NONE;
    end else if (state_r == ST_IDLE && start) begin
      inject_r <= inject_t'(inject_sel);
      if (run_all || slice_count == '0) begin
        slice_r <= '0;
        last_slice_r <= SLICE_WIDTH'(NUM_SLICES - 1);
      end else begin
        slice_r <= slice_first;
        last_slice_r <= slice_first + slice_count - 1'b1;
      end
    end else if (sig_step && slice_end && slice_r != last_slice_r) begin
      slice_r <= slice_r + 1'b1;
    end
  end

  // Pattern generator feeding the scan chains.
  always_ff @(posedge clk) begin
    if (rst) begin
      lfsr_r <= LFSR_SEED;
      pat_r <= '0;
    end else if (state_r == ST_SAVE) begin
      lfsr_r <= LFSR_SEED ^ {24'h00_0000, slice_r};
      pat_r <= '0;
    end else if (sig_step) begin
      lfsr_r <= {lfsr_r[30:0], ^(lfsr_r & LFSR_TAPS)};
      pat_r <= slice_end ? 16'h0000 : pat_r + 16'h0001;
    end
  end

  // Timeout counter, armed unconditionally whenever scanning.
  always_ff @(posedge clk) begin
    if (rst || state_r != ST_SCAN) begin
      timer_r <= '0;
    end else begin
      timer_r <= timer_r + 32'h0000_0001;
    end
  end

  // Core reset pulse length.
  always_ff @(posedge clk) begin
    if (rst || state_r != ST_RESET) begin
      rst_cnt_r <= '0;
    end else begin
      rst_cnt_r <= rst_cnt_r + 8'h01;
    end
  end

  // Outcome status; only the device reset, a new start or software clear wipes the flags, and only the device reset wipes stat_signature.
  always_ff @(posedge clk) begin
    if (rst) begin
      stat_done <= 1'b0;
      stat_pass <= 1'b0;
      stat_mismatch <= 1'b0;
      stat_timeout <= 1'b0;
      stat_signature <= '0;
      fail_r <= 1'b0;
    end else if (state_r == ST_IDLE && start) begin
      stat_done <= 1'b0;
      stat_pass <= 1'b0;
      stat_mismatch <= 1'b0;
      stat_timeout <= 1'b0;
      fail_r <= 1'b0;
    end else if (timeout_hit) begin
      stat_timeout <= 1'b1;
      stat_done <= 1'b1;
      stat_signature <= signature;
      fail_r <= 1'b1;
    end else if (state_r == ST_CHECK) begin
      stat_done <= 1'b1;
      stat_signature <= signature;
      // Flipping the low bit proves the comparator catches corruption.
      if ((signature ^ {{(SIG_WIDTH-1){1'b0}}, inject_r == INJ_SIGNATURE}) == EXPECTED_SIG) begin
        stat_pass <= 1'b1;
      end else begin
        stat_mismatch <= 1'b1;
        fail_r <= 1'b1;
      end
    end else if (status_clear && state_r == ST_IDLE) begin
      stat_done <= 1'b0;
      stat_pass <= 1'b0;
      stat_mismatch <= 1'b0;
      stat_timeout <= 1'b0;
    end
  end

  // Error signalling: all cores get the NMI; it holds until the next run or clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      nmi <= '0;
      error_status_pin <= 1'b0;
    end else if (state_r == ST_RESTORE && fail_r) begin
      nmi <= '1;
      error_status_pin <= 1'b1;
    end else if ((state_r == ST_IDLE && (start || status_clear))) begin
      nmi <= '0;
      error_status_pin <= 1'b0;
    end
  end

  // Registered scan and core control.
  always_ff @(posedge clk) begin
    if (rst) begin
      scan_enable <= 1'b0;
      scan_in <= '0;
      context_save <= 1'b0;
      context_restore <= 1'b0;
      core_reset <= 1'b0;
      busy <= 1'b0;
    end else begin
      scan_enable <= sig_step && !timeout_hit;
      scan_in <= lfsr_r[CHAIN_COUNT-1:0];
      context_save <= (state_r == ST_IDLE) && start;
      context_restore <= (state_r == ST_RESET) && (rst_cnt_r == 8'(CORE_RESET_CYC - 1));
      core_reset <= (state_r == ST_CHECK) || timeout_hit || 
                    ((state_r == ST_RESET) && (rst_cnt_r != 8'(CORE_RESET_CYC - 1)));
      busy <= (state_r != ST_IDLE) || start;
    end
  end
endmodule

// file: core_model.sv
`timescale 1ns/1ps
// Model of the processor scan chains facing the self-test supervisor.
// Assumes a healthy core compacts to the all-zero expected signature.
module core_model
  import self_test_pkg::*;
(
  // Scan access.
  input wire logic scan_enable,
  input wire logic [CHAIN_COUNT-1:0] scan_in,
  // Inverting fault select.
  input wire logic bad,
  // Chain responses.
  output logic [CHAIN_COUNT-1:0] scan_out
);
  // A faulty core echoes inverted patterns so the compacted signature differs.
  assign scan_out = (bad && scan_enable) ? ~scan_in : '0;
endmodule

// file: st_chk.sv
`timescale 1ns/1ps
// Port assertions for the processor self-test supervisor.
// Assumes a bind onto the supervisor, one clock and a synchronous reset.
module st_chk
  import self_test_pkg::*;
#(
  parameter int unsigned NUM_CORES = 2,
  parameter logic [SIG_WIDTH-1:0] EXPECTED_SIG = '0
) (
  // Clock, reset and request.
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  // Watched outputs.
  input wire logic context_save,
  input wire logic context_restore,
  input wire logic core_reset,
  input wire logic [NUM_CORES-1:0] nmi,
  input wire logic error_status_pin,
  input wire logic busy,
  input wire logic stat_done,
  input wire logic stat_pass,
  input wire logic stat_mismatch,
  input wire logic stat_timeout,
  input wire logic [SIG_WIDTH-1:0] stat_signature
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence reset_hold_s;
    core_reset [*8];
  endsequence
  sequence alarm_s;
    ##[1:20] (&nmi && error_status_pin);
  endsequence
  AST_START_SAVE: assert property (start && !busy |=> context_save && busy)
    else $error("no context save after start");
  AST_NO_SELF_START: assert property ($rose(busy) |-> $past(start))
    else $error("run began without start");
  AST_RESTORE: assert property (
    $rose(core_reset) |-> reset_hold_s ##[0:4] context_restore)
    else $error("core reset not followed by restore");
  AST_FAIL_NMI: assert property ($rose(stat_mismatch) |-> alarm_s)
    else $error("mismatch without nmi");
  AST_TIMEOUT: assert property (
    $rose(stat_timeout) |-> ##[0:3] core_reset ##0 alarm_s)
    else $error("timeout without reset and nmi");
  AST_RUN_BOUND: assert property ($rose(busy) |-> ##[1:1000] !busy)
    else $error("run never ended");
  AST_HOLD: assert property (
    core_reset && $past(core_reset) |->
    $stable({stat_done, stat_pass, stat_mismatch, stat_timeout}))
    else $error("status changed during core reset");
  AST_PASS_SIG: assert property (stat_pass |-> stat_signature == EXPECTED_SIG)
    else $error("pass with wrong signature");
  AST_ONE_OUTCOME: assert property (
    stat_done |-> $onehot({stat_pass, stat_mismatch, stat_timeout}))
    else $error("outcome flags not exclusive");
endmodule
bind cpu_self_test_supervisor st_chk #(.NUM_CORES(NUM_CORES), .EXPECTED_SIG(EXPECTED_SIG)) chk (
  .clk(clk), .rst(rst), .start(start), .context_save(context_save),
  .context_restore(context_restore), .core_reset(core_reset), .nmi(nmi),
  .error_status_pin(error_status_pin), .busy(busy), .stat_done(stat_done),
  .stat_pass(stat_pass), .stat_mismatch(stat_mismatch), .stat_timeout(stat_timeout),
  .stat_signature(stat_signature));

// file: tb.sv
`timescale 1ns/1ps
// Self-checking bench for the self-test supervisor and a core model.
// Assumes shortened slice and timeout counts set at the instance.
module tb;
  import self_test_pkg::*;
  logic clk = 0, rst = 1, start = 0, run_all = 0, status_clear = 0, bad = 0;
  logic [7:0] slice_first = 0, slice_count = 1;
  logic [1:0] inject_sel = 0, nmi;
  logic scan_enable, context_save, context_restore, core_reset, error_status_pin, busy;
  logic stat_done, stat_pass, stat_mismatch, stat_timeout;
  logic [CHAIN_COUNT-1:0] scan_in, scan_out;
  logic [SIG_WIDTH-1:0] stat_signature;
  logic [6:0] flags;
  localparam int SLICES = 4;
  localparam int PATS = 8;
  int miscompares = 0, checks_done = 0, saves = 0;
  int shifts = 0, base = 0, saves_base = 0, n_exp = 0;
  // Row: run_all, count, inject, bad core, then done pass mismatch timeout pin nmi.
  logic [18:0] rows [6] = '{{1'b0, 8'd1, 2'd0, 1'b0, 7'b1100000},
    {1'b1, 8'd0, 2'd0, 1'b0, 7'b1100000}, {1'b0, 8'd0, 2'd0, 1'b0, 7'b1100000},
    {1'b0, 8'd2, 2'd0, 1'b1, 7'b1010111}, {1'b0, 8'd1, 2'd1, 1'b0, 7'b1010111},
    {1'b0, 8'd1, 2'd2, 1'b0, 7'b1001111}};
  assign flags = {stat_done, stat_pass, stat_mismatch, stat_timeout, error_status_pin, nmi};
  always #5 clk = ~clk;
  always @(posedge clk) if (context_save === 1'b1) saves++;
  always @(posedge clk) if (scan_enable === 1'b1) shifts++;
  cpu_self_test_supervisor #(.NUM_SLICES(SLICES), .TIMEOUT_CYCLES(200), .SLICE_PATTERNS(PATS)) DUT (
    .clk, .rst, .start, .run_all, .slice_first, .slice_count, .inject_sel, .status_clear,
    .scan_enable, .scan_in, .scan_out, .context_save, .context_restore, .core_reset, .nmi,
    .error_status_pin, .busy, .stat_done, .stat_pass, .stat_mismatch, .stat_timeout,
    .stat_signature);
  core_model model (.scan_enable, .scan_in, .bad, .scan_out);
  task automatic chk_flags(input logic [6:0] exp);
    checks_done++;
    if (flags !== exp) begin
      miscompares++;
      $display("wrong value at %0t: flags %b expected %b", $time, flags, exp);
    end
  endtask
  task automatic chk_val(input logic [SIG_WIDTH-1:0] got, input logic [SIG_WIDTH-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: value %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic run(input logic [18:0] r);
    int n = 0;
    {run_all, slice_count, inject_sel, bad} = r[18:7];
    start = 1;
    @(posedge clk) #1;
    start = 0;
    repeat (2) @(posedge clk) #1;
    while (busy !== 1'b0 && n < 600) begin
      @(posedge clk) #1;
      n++;
    end
    if (n == 600) begin
      miscompares++;
      $display("wrong value at %0t: run never finished", $time);
      test_done;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic test_done;
    if (miscompares == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    test_done;
  end
  initial begin
    repeat (12) @(posedge clk);
    #1 rst = 0;
    chk_flags(7'b0);
    foreach (rows[i]) begin
      base = shifts;
      run(rows[i]);
      chk_flags(rows[i][6:0]);
      // A hang run shifts nothing; otherwise every chosen slice shifts all its patterns.
      n_exp = (rows[i][18] || rows[i][17:10] == 8'h00) ? SLICES : int'(rows[i][17:10]);
      if (rows[i][9:8] == 2'd2) n_exp = 0;
      chk_val(SIG_WIDTH'(shifts - base), SIG_WIDTH'(n_exp * PATS));
    end
    status_clear = 1;
    @(posedge clk) #1;
    status_clear = 0;
    @(posedge clk) #1;
    chk_flags(7'b0);
    saves_base = saves;
    fork
      run({1'b1, 8'd0, 2'd0, 1'b0, 7'b0});
      begin
        repeat (6) @(posedge clk);
        #1 start = 1;
        @(posedge clk) #1 start = 0;
      end
    join
    chk_val(SIG_WIDTH'(saves - saves_base), SIG_WIDTH'(1));
    chk_flags(7'b1100000);
    chk_val(stat_signature, '0);
    // Reset in the middle of a hung run must wipe the flags, busy, core_reset, scan_enable and context_save, and allow a fresh run.
    inject_sel = 2'd2;
    start = 1;
    @(posedge clk) #1;
    start = 0;
    repeat (20) @(posedge clk);
    #1 rst = 1;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    chk_flags(7'b0);
    chk_val(SIG_WIDTH'({busy, core_reset, scan_enable, context_save}), '0);
    run(rows[0]);
    chk_flags(rows[0][6:0]);
    test_done;
  end
endmodule
